// ==== logic/drs_persist_timer.sv ====
// persistence timer: flags a condition that has held for LIMIT cycles
`timescale 1ns/1ns
`default_nettype none
module drs_persist_timer #(
   parameter drs_pkg::drs_cnt_t LIMIT = drs_pkg::drs_cnt_t'(drs_pkg::PERSIST_CYC)
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic cond,
   input  wire logic clear,
   output var  logic expired
);

   drs_pkg::drs_cnt_t cnt_q;
   drs_pkg::drs_cnt_t cnt_d;
   logic              exp_q;
   logic              exp_d;

   always_comb begin
      // any gap in the condition restarts the count
      if (clear || !cond) begin
         cnt_d = drs_pkg::CNT_RST;
      end else if (cnt_q != LIMIT) begin
         cnt_d = drs_pkg::drs_cnt_t'(cnt_q + 1'b1);
      end else begin
         cnt_d = cnt_q;
      end
      exp_d = (cnt_d == LIMIT);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_q <= drs_pkg::CNT_RST;
         exp_q <= drs_pkg::FLAG_RST;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expired = exp_q;

endmodule
`default_nettype wire

// ==== logic/drs_pkg.sv ====
// shared constants and types for the display rail fault supervisor
package drs_pkg;

   localparam int unsigned CLK_PERIOD_NS       = 10;
   localparam int unsigned NS_PER_US           = 1000;

   // timing figures in microseconds
   localparam int unsigned PERSIST_US          = 1000;
   localparam int unsigned POS_REG_DEADLINE_US = 10000;
   localparam int unsigned NEG_ENABLE_DELAY_US = 10000;
   localparam int unsigned NEG_REG_DEADLINE_US = 12500;

   // least times, rounded up to whole cycles
   localparam int unsigned PERSIST_CYC =
      (PERSIST_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned POS_REG_DEADLINE_CYC =
      (POS_REG_DEADLINE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned NEG_ENABLE_DELAY_CYC =
      (NEG_ENABLE_DELAY_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned NEG_REG_DEADLINE_CYC =
      (NEG_REG_DEADLINE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int unsigned CNT_W = 24;
   typedef logic [CNT_W-1:0] drs_cnt_t;

   // reset and saturation values
   localparam drs_cnt_t CNT_RST  = 24'h000000;
   localparam drs_cnt_t CNT_MAX  = 24'hffffff;
   localparam logic     FLAG_RST = 1'b0;

   // persistence timer slots
   localparam int unsigned PT_POS_OC   = 0;
   localparam int unsigned PT_ANA_OC   = 1;
   localparam int unsigned PT_ANA_LOW  = 2;
   localparam int unsigned PT_POS_LOW  = 3;
   localparam int unsigned PT_NEG_HIGH = 4;
   localparam int unsigned PT_NUM      = 5;

   typedef enum logic [2:0] {
      DRS_IDLE,
      DRS_POS_START,
      DRS_NEG_START,
      DRS_RUN,
      DRS_SHUT_ALL,
      DRS_PANEL_OFF
   } drs_seq_e;

endpackage

// ==== logic/drs_supervisor.sv ====
// fault supervisor and start-up sequencer for three display supply rails
//
// Notes on behaviour
// - input near positive rail: keep its high-side switch off, body diode rectifies
// - positive rail overcurrent for 1ms latches, shuts all; cleared by control low or reset
// - analog rail overcurrent for 1ms latches shutdown; released by enable toggle or reset
// - positive rail not in regulation 10ms after control rise: shut all outputs
// - negative rail not regulated 12.5ms after its enable, 22.5ms total: shut all
// - negative rail above 250mV at its enable: shut panel rails, analog keeps running
// - analog rail at or below 90 percent for 1ms with ctrl high: shut all outputs
// - positive rail at or below 80 percent for 1ms once both panel rails are up: shut all outputs
// - negative rail above 600mV for 1ms once both panel rails are up: shut all outputs
// - over thermal trip shut down; restart automatically once 25C cooler
`timescale 1ns/1ns
`default_nettype none
module drs_supervisor #(
   parameter int unsigned PERSIST_CYC          = drs_pkg::PERSIST_CYC,
   parameter int unsigned POS_REG_DEADLINE_CYC = drs_pkg::POS_REG_DEADLINE_CYC,
   parameter int unsigned NEG_ENABLE_DELAY_CYC = drs_pkg::NEG_ENABLE_DELAY_CYC,
   parameter int unsigned NEG_REG_DEADLINE_CYC = drs_pkg::NEG_REG_DEADLINE_CYC
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic ctrl,
   input  wire logic ana_rail_enable,
   input  wire logic vin_near_pos_rail,
   input  wire logic pos_overcurrent,
   input  wire logic ana_overcurrent,
   input  wire logic pos_in_regulation,
   input  wire logic neg_in_regulation,
   input  wire logic pos_below_80pct,
   input  wire logic ana_below_90pct,
   input  wire logic negative_panel_rail_above_600mv,
   input  wire logic negative_panel_rail_above_250mv,
   input  wire logic short_check_enable,
   input  wire logic temp_over_thermal_trip_threshold,
   input  wire logic temp_below_restart_threshold,
   output var  logic pos_rail_enable,
   output var  logic negative_panel_rail_enable,
   output var  logic ana_rail_on,
   output var  logic high_side_switch_enable,
   output var  logic diode_mode,
   output var  logic pos_overcurrent_trip,
   output var  logic ana_overcurrent_trip,
   output var  logic all_rails_shutdown,
   output var  logic panel_rails_shutdown,
   output var  logic thermal_shutdown
);

   localparam drs_pkg::drs_cnt_t PERSIST_LIM = drs_pkg::drs_cnt_t'(PERSIST_CYC);
   localparam drs_pkg::drs_cnt_t POS_DL_LIM  = drs_pkg::drs_cnt_t'(POS_REG_DEADLINE_CYC);
   localparam drs_pkg::drs_cnt_t NEG_EN_LIM  = drs_pkg::drs_cnt_t'(NEG_ENABLE_DELAY_CYC);
   localparam drs_pkg::drs_cnt_t NEG_DL_LIM  =
      drs_pkg::drs_cnt_t'(NEG_ENABLE_DELAY_CYC + NEG_REG_DEADLINE_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // state

   drs_pkg::drs_seq_e seq_q;
   drs_pkg::drs_seq_e seq_d;
   drs_pkg::drs_cnt_t seq_cnt_q;
   drs_pkg::drs_cnt_t seq_cnt_d;
   logic              pos_ok_q;
   logic              pos_ok_d;
   logic              pos_oct_q;
   logic              pos_oct_d;
   logic              ana_oct_q;
   logic              ana_oct_d;

   logic              pos_en_q;
   logic              pos_en_d;
   logic              neg_en_q;
   logic              neg_en_d;
   logic              ana_on_q;
   logic              ana_on_d;
   logic              hs_en_q;
   logic              hs_en_d;
   logic              diode_q;
   logic              diode_d;
   logic              all_shut_q;
   logic              all_shut_d;
   logic              panel_shut_q;
   logic              panel_shut_d;
   logic              therm_q;
   logic              therm_d;

   logic              hot;
   logic              active;
   logic              run_fault;
   logic              pos_seen;
   logic              pos_late;
   logic              neg_due;
   logic              neg_late;
   logic              short_hit;
   logic              ana_trip;
   logic [drs_pkg::PT_NUM-1:0] pt_cond;
   logic [drs_pkg::PT_NUM-1:0] pt_clear;
   logic [drs_pkg::PT_NUM-1:0] pt_exp;

   ////////////////////////////////////////////////////////////////////////////
   // persistence timers

   always_comb begin
      pt_cond                       = '0;
      pt_clear                      = '0;
      pt_cond[drs_pkg::PT_POS_OC]   = pos_overcurrent;
      pt_clear[drs_pkg::PT_POS_OC]  = !pos_en_q;
      pt_cond[drs_pkg::PT_ANA_OC]   = ana_overcurrent;
      pt_clear[drs_pkg::PT_ANA_OC]  = !ana_on_q;
      pt_cond[drs_pkg::PT_ANA_LOW]  = ana_below_90pct;
      pt_clear[drs_pkg::PT_ANA_LOW] = !ana_on_q;
      pt_cond[drs_pkg::PT_POS_LOW]  = pos_below_80pct;
      // only watched once both panel rails are up, not while ramping
      pt_clear[drs_pkg::PT_POS_LOW] = (seq_q != drs_pkg::DRS_RUN);
      pt_cond[drs_pkg::PT_NEG_HIGH] = negative_panel_rail_above_600mv;
      pt_clear[drs_pkg::PT_NEG_HIGH] = (seq_q != drs_pkg::DRS_RUN);
   end

   genvar gi;
   generate
      for (gi = 0; gi < drs_pkg::PT_NUM; gi = gi + 1) begin : g_pt
         drs_persist_timer #(
            .LIMIT   (PERSIST_LIM)
         ) u_pt (
            .clk     (clk),
            .resetn  (resetn),
            .cond    (pt_cond[gi]),
            .clear   (pt_clear[gi]),
            .expired (pt_exp[gi])
         );
      end
   endgenerate

   drs_thermal_guard u_therm (
      .clk         (clk),
      .resetn      (resetn),
      .over_upper  (temp_over_thermal_trip_threshold),
      .below_lower (temp_below_restart_threshold),
      .hot         (hot)
   );

   ////////////////////////////////////////////////////////////////////////////
   // analog overcurrent latch

   assign ana_trip = pt_exp[drs_pkg::PT_ANA_OC];

   always_comb begin
      // released by its own enable, independent of ctrl
      if (!ana_rail_enable) begin
         ana_oct_d = 1'b0;
      end else if (ana_trip) begin
         ana_oct_d = 1'b1;
      end else begin
         ana_oct_d = ana_oct_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ana_oct_q <= drs_pkg::FLAG_RST;
      end else begin
         ana_oct_q <= ana_oct_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   assign active = (seq_q == drs_pkg::DRS_POS_START) || (seq_q == drs_pkg::DRS_NEG_START) ||
                   (seq_q == drs_pkg::DRS_RUN) || (seq_q == drs_pkg::DRS_PANEL_OFF);

   assign run_fault = (seq_q == drs_pkg::DRS_RUN) &&
                      (pt_exp[drs_pkg::PT_POS_LOW] || pt_exp[drs_pkg::PT_NEG_HIGH]);

   // windows end one count early so the move lands on the edge that closes them
   assign pos_seen  = pos_ok_q || pos_in_regulation;
   assign pos_late  = (seq_cnt_q >= POS_DL_LIM - 1'b1) && !pos_seen;
   assign neg_due   = (seq_cnt_q >= NEG_EN_LIM - 1'b1);
   assign neg_late  = (seq_cnt_q >= NEG_DL_LIM - 1'b1);
   // short check only matters on the edge that enables the negative rail
   assign short_hit = short_check_enable && negative_panel_rail_above_250mv;

   always_comb begin
      seq_d     = seq_q;
      seq_cnt_d = (seq_cnt_q == drs_pkg::CNT_MAX) ? seq_cnt_q : drs_pkg::drs_cnt_t'(seq_cnt_q + 1'b1);
      pos_ok_d  = pos_seen;
      pos_oct_d = pos_oct_q;

      if (!ctrl) begin
         seq_d     = drs_pkg::DRS_IDLE;
         pos_oct_d = 1'b0;
      end else if (active && pt_exp[drs_pkg::PT_POS_OC] && pos_en_q) begin
         seq_d     = drs_pkg::DRS_SHUT_ALL;
         pos_oct_d = 1'b1;
      end else if (active && pt_exp[drs_pkg::PT_ANA_LOW]) begin
         seq_d = drs_pkg::DRS_SHUT_ALL;
      end else if (run_fault) begin
         seq_d = drs_pkg::DRS_SHUT_ALL;
      end else if (active && (hot || ana_oct_d)) begin
         // thermal and analog trips are not ctrl latches: back to idle, resequence later
         seq_d = drs_pkg::DRS_IDLE;
      end else begin
         case (seq_q)
            drs_pkg::DRS_IDLE: begin
               if (!hot && !ana_oct_d) begin
                  seq_d     = drs_pkg::DRS_POS_START;
                  seq_cnt_d = drs_pkg::CNT_RST;
                  pos_ok_d  = 1'b0;
               end
            end
            drs_pkg::DRS_POS_START: begin
               if (pos_late) begin
                  seq_d = drs_pkg::DRS_SHUT_ALL;
               end else if (neg_due) begin
                  if (short_hit) begin
                     seq_d = drs_pkg::DRS_PANEL_OFF;
                  end else begin
                     seq_d = drs_pkg::DRS_NEG_START;
                  end
               end
            end
            drs_pkg::DRS_NEG_START: begin
               if (neg_in_regulation) begin
                  seq_d = drs_pkg::DRS_RUN;
               end else if (neg_late) begin
                  seq_d = drs_pkg::DRS_SHUT_ALL;
               end
            end
            drs_pkg::DRS_RUN: begin
               seq_d = drs_pkg::DRS_RUN;
            end
            drs_pkg::DRS_SHUT_ALL: begin
               seq_d = drs_pkg::DRS_SHUT_ALL;
            end
            drs_pkg::DRS_PANEL_OFF: begin
               seq_d = drs_pkg::DRS_PANEL_OFF;
            end
            default: begin
               seq_d = drs_pkg::DRS_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   always_comb begin
      pos_en_d = (seq_d == drs_pkg::DRS_POS_START) || (seq_d == drs_pkg::DRS_NEG_START) ||
                 (seq_d == drs_pkg::DRS_RUN);
      neg_en_d = (seq_d == drs_pkg::DRS_NEG_START) || (seq_d == drs_pkg::DRS_RUN);
      // panel-only shutdown leaves the analog rail alone
      ana_on_d = ana_rail_enable && !ana_oct_d && !hot &&
                 (seq_d != drs_pkg::DRS_SHUT_ALL);
      diode_d  = pos_en_d && vin_near_pos_rail;
      hs_en_d  = pos_en_d && !vin_near_pos_rail;
      all_shut_d   = (seq_d == drs_pkg::DRS_SHUT_ALL);
      panel_shut_d = (seq_d == drs_pkg::DRS_PANEL_OFF);
      therm_d      = hot;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         seq_q        <= drs_pkg::DRS_IDLE;
         seq_cnt_q    <= drs_pkg::CNT_RST;
         pos_ok_q     <= drs_pkg::FLAG_RST;
         pos_oct_q    <= drs_pkg::FLAG_RST;
         pos_en_q     <= drs_pkg::FLAG_RST;
         neg_en_q     <= drs_pkg::FLAG_RST;
         ana_on_q     <= drs_pkg::FLAG_RST;
         hs_en_q      <= drs_pkg::FLAG_RST;
         diode_q      <= drs_pkg::FLAG_RST;
         all_shut_q   <= drs_pkg::FLAG_RST;
         panel_shut_q <= drs_pkg::FLAG_RST;
         therm_q      <= drs_pkg::FLAG_RST;
      end else begin
         seq_q        <= seq_d;
         seq_cnt_q    <= seq_cnt_d;
         pos_ok_q     <= pos_ok_d;
         pos_oct_q    <= pos_oct_d;
         pos_en_q     <= pos_en_d;
         neg_en_q     <= neg_en_d;
         ana_on_q     <= ana_on_d;
         hs_en_q      <= hs_en_d;
         diode_q      <= diode_d;
         all_shut_q   <= all_shut_d;
         panel_shut_q <= panel_shut_d;
         therm_q      <= therm_d;
      end
   end

   assign pos_rail_enable            = pos_en_q;
   assign negative_panel_rail_enable = neg_en_q;
   assign ana_rail_on                = ana_on_q;
   assign high_side_switch_enable    = hs_en_q;
   assign diode_mode                 = diode_q;
   assign pos_overcurrent_trip       = pos_oct_q;
   assign ana_overcurrent_trip       = ana_oct_q;
   assign all_rails_shutdown         = all_shut_q;
   assign panel_rails_shutdown       = panel_shut_q;
   assign thermal_shutdown           = therm_q;

endmodule
`default_nettype wire

// ==== logic/drs_thermal_guard.sv ====
// die temperature hysteresis between upper trip and lower restart levels
`timescale 1ns/1ns
`default_nettype none
module drs_thermal_guard (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic over_upper,
   input  wire logic below_lower,
   output var  logic hot
);

   logic hot_q;
   logic hot_d;

   always_comb begin
      // the band between the two levels keeps the last decision
      if (hot_q) begin
         hot_d = !below_lower;
      end else begin
         hot_d = over_upper;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         hot_q <= drs_pkg::FLAG_RST;
      end else begin
         hot_q <= hot_d;
      end
   end

   assign hot = hot_q;

endmodule
`default_nettype wire

// ==== tb/drs_host_model.sv ====
// host model that drives the control pin and the analog rail enable
`timescale 1ns/1ns
`default_nettype none
module drs_host (
   input  wire logic clk,
   input  wire logic want_ctrl,
   input  wire logic want_ana,
   output var  logic ctrl,
   output var  logic ana_rail_enable
);
   initial begin
      ctrl = 1'b0;
      ana_rail_enable = 1'b0;
   end
   // falling edge launch keeps both pins clear of the sampling edge
   always @(negedge clk) begin
      ctrl <= want_ctrl;
      ana_rail_enable <= want_ana;
   end
endmodule
`default_nettype wire

// ==== tb/drs_supervisor_assertions.sv ====
// concurrent checks on the rail fault supervisor ports
`timescale 1ns/1ns
`default_nettype none
module drs_supervisor_chk #(
   parameter int unsigned PERSIST_CYC          = 20,
   parameter int unsigned NEG_ENABLE_DELAY_CYC = 50
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ctrl,
   input wire logic ana_rail_enable,
   input wire logic pos_overcurrent,
   input wire logic ana_overcurrent,
   input wire logic pos_rail_enable,
   input wire logic negative_panel_rail_enable,
   input wire logic ana_rail_on,
   input wire logic high_side_switch_enable,
   input wire logic diode_mode,
   input wire logic pos_overcurrent_trip,
   input wire logic ana_overcurrent_trip,
   input wire logic all_rails_shutdown,
   input wire logic panel_rails_shutdown,
   input wire logic thermal_shutdown
);
   ////////////////////////////////////////
   // run lengths saturate so long holds never wrap
   drs_pkg::drs_cnt_t poc_q, poc_d, aoc_q, aoc_d, on_q, on_d;
   always_comb begin
      poc_d = !pos_overcurrent ? drs_pkg::CNT_RST : (&poc_q) ? poc_q : poc_q + 24'h000001;
      aoc_d = !ana_overcurrent ? drs_pkg::CNT_RST : (&aoc_q) ? aoc_q : aoc_q + 24'h000001;
      on_d  = !pos_rail_enable ? drs_pkg::CNT_RST : (&on_q) ? on_q : on_q + 24'h000001;
   end
   always_ff @(posedge clk) begin
      poc_q <= resetn ? poc_d : drs_pkg::CNT_RST;
      aoc_q <= resetn ? aoc_d : drs_pkg::CNT_RST;
      on_q  <= resetn ? on_d : drs_pkg::CNT_RST;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_pos_rise;
      !pos_rail_enable ##1 pos_rail_enable;
   endsequence
   sequence s_neg_rise;
      !negative_panel_rail_enable ##1 negative_panel_rail_enable;
   endsequence
   a_diode_excl: assert property (diode_mode |-> !high_side_switch_enable && pos_rail_enable)
      else $error("diode mode with high side switch on");
   a_start_ctrl: assert property (s_pos_rise |-> $past(ctrl))
      else $error("positive rail started without control high");
   a_neg_en_time: assert property (s_neg_rise |-> on_q inside {[NEG_ENABLE_DELAY_CYC-1:NEG_ENABLE_DELAY_CYC]})
      else $error("negative rail enable at wrong time");
   a_ctrl_low_clr: assert property (!ctrl |=> !pos_rail_enable && !negative_panel_rail_enable
      && !pos_overcurrent_trip && !all_rails_shutdown && !panel_rails_shutdown)
      else $error("control low did not clear panel state");
   a_pos_oc_hold: assert property (pos_overcurrent_trip && ctrl |=> pos_overcurrent_trip)
      else $error("positive overcurrent latch dropped");
   a_pos_oc_time: assert property ($rose(pos_overcurrent_trip) |-> $past(poc_q) >= PERSIST_CYC)
      else $error("positive overcurrent tripped early");
   a_ana_oc_hold: assert property (ana_overcurrent_trip && ana_rail_enable |=> ana_overcurrent_trip)
      else $error("analog overcurrent latch dropped");
   a_ana_oc_time: assert property ($rose(ana_overcurrent_trip) |-> $past(aoc_q) >= PERSIST_CYC)
      else $error("analog overcurrent tripped early");
   a_ana_release: assert property (!ana_rail_enable |=> !ana_overcurrent_trip && !ana_rail_on)
      else $error("analog enable low did not release");
   a_shut_all_off: assert property (all_rails_shutdown |-> !pos_rail_enable
      && !negative_panel_rail_enable && !ana_rail_on)
      else $error("rail on during full shutdown");
   a_pos_oc_shut: assert property (pos_overcurrent_trip |-> all_rails_shutdown)
      else $error("positive overcurrent without full shutdown");
   a_panel_off: assert property (panel_rails_shutdown |-> !pos_rail_enable && !negative_panel_rail_enable)
      else $error("panel rail on during panel shutdown");
   a_thermal_off: assert property (thermal_shutdown |-> !pos_rail_enable && !ana_rail_on)
      else $error("rail on while hot");
endmodule
bind drs_supervisor drs_supervisor_chk #(
   .PERSIST_CYC(PERSIST_CYC),
   .NEG_ENABLE_DELAY_CYC(NEG_ENABLE_DELAY_CYC)
) u_chk (
   .clk, .resetn, .ctrl, .ana_rail_enable, .pos_overcurrent, .ana_overcurrent,
   .pos_rail_enable, .negative_panel_rail_enable, .ana_rail_on, .high_side_switch_enable,
   .diode_mode, .pos_overcurrent_trip, .ana_overcurrent_trip, .all_rails_shutdown,
   .panel_rails_shutdown, .thermal_shutdown
);
`default_nettype wire

// ==== tb/drs_supervisor_tb.sv ====
// self-checking bench for the rail fault supervisor
`timescale 1ns/1ns
`default_nettype none
module drs_supervisor_tb;
   // shortened counts keep the run brief
   localparam int unsigned PC = 20;
   localparam int unsigned PD = 40;
   localparam int unsigned NE = 50;
   localparam int unsigned ND = 60;
   logic       clk, resetn, want_ctrl, want_ana, ctrl, ana_en, vin, poc, aoc, preg, nreg;
   logic       p80, a90, n600, n250, sce, hot_in, cool;
   wire  [9:0] o;
   int         fail_count, samples_checked, seed, el, g, k;
   ////////////////////////////////////////
   drs_host HOST (.clk(clk), .want_ctrl(want_ctrl), .want_ana(want_ana), .ctrl(ctrl), .ana_rail_enable(ana_en));
   drs_supervisor #(.PERSIST_CYC(PC), .POS_REG_DEADLINE_CYC(PD), .NEG_ENABLE_DELAY_CYC(NE),
      .NEG_REG_DEADLINE_CYC(ND)) DUT (
      .clk(clk), .resetn(resetn), .ctrl(ctrl), .ana_rail_enable(ana_en), .vin_near_pos_rail(vin),
      .pos_overcurrent(poc), .ana_overcurrent(aoc), .pos_in_regulation(preg), .neg_in_regulation(nreg),
      .pos_below_80pct(p80), .ana_below_90pct(a90), .negative_panel_rail_above_600mv(n600),
      .negative_panel_rail_above_250mv(n250), .short_check_enable(sce),
      .temp_over_thermal_trip_threshold(hot_in), .temp_below_restart_threshold(cool),
      .pos_rail_enable(o[0]), .negative_panel_rail_enable(o[1]), .ana_rail_on(o[2]),
      .high_side_switch_enable(o[3]), .diode_mode(o[4]), .pos_overcurrent_trip(o[5]),
      .ana_overcurrent_trip(o[6]), .all_rails_shutdown(o[7]), .panel_rails_shutdown(o[8]),
      .thermal_shutdown(o[9]));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic conclude();
      if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      samples_checked++;
      if (a !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   // diode mode replaces the high-side switch whenever the input sits near the rail
   function automatic logic [1:0] sw_exp(input logic near);
      return {near, ~near};
   endfunction
   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic rst();
      resetn <= 1'b0;
      want_ctrl <= 1'b0;
      want_ana <= 1'b1;
      {vin, poc, aoc, preg, nreg, p80, a90, n600, n250, sce, hot_in, cool} <= 12'h000;
      cyc(6);
      chk(32'(o), 32'h0);
      resetn <= 1'b1;
      cyc(2);
   endtask
   // host pin lags its request by one falling edge
   task automatic go();
      want_ctrl <= 1'b1;
      cyc(1);
      el = 0;
   endtask
   // bounded wait; elapsed cycles must land in the window
   task automatic wt(input int b, input logic v, input int lo, input int hi);
      while (o[b] !== v && el <= hi) begin
         cyc(1);
         el++;
      end
      chk(32'((el >= lo && el <= hi) ? lo : el), 32'(lo));
   endtask
   task automatic flt(input int f, input logic v);
      case (f)
         0: p80 <= v;
         1: a90 <= v;
         default: n600 <= v;
      endcase
   endtask
   initial begin
      cyc(20000);
      fail_count++;
      conclude();
   end
   ////////////////////////////////////////
   initial begin
      seed = 32'h9f7bd17e;
      fail_count = 0;
      samples_checked = 0;
      {resetn, want_ctrl, want_ana, vin, poc, aoc, preg, nreg} = 8'h00;
      {p80, a90, n600, n250, sce, hot_in, cool} = 7'h00;
      for (k = 0; k < 3; k++) begin
         rst();
         vin <= 1'($random(seed));
         sce <= 1'($random(seed));
         preg <= 1'b1;
         go();
         wt(0, 1'b1, 1, 2);
         chk(32'(o[4:3]), 32'(sw_exp(vin)));
         wt(1, 1'b1, NE - 1, NE + 1);
         nreg <= 1'b1;
         vin <= ~vin;
         cyc(3);
         chk(32'(o[4:3]), 32'(sw_exp(vin)));
         g = 1 + {$random(seed)} % (PC - 2);
         flt(k, 1'b1);
         cyc(g);
         flt(k, 1'b0);
         cyc(PC + 4);
         chk(32'(o[7]), 32'h0);
         flt(k, 1'b1);
         el = 0;
         wt(7, 1'b1, PC, PC + 3);
         chk(32'(o[2:0]), 32'h0);
         flt(k, 1'b0);
         want_ctrl <= 1'b0;
         cyc(3);
         chk(32'(o[7]), 32'h0);
      end
      rst();
      preg <= 1'b1;
      go();
      wt(0, 1'b1, 1, 2);
      poc <= 1'b1;
      el = 0;
      wt(5, 1'b1, PC, PC + 3);
      chk(32'(o[7]), 32'h1);
      poc <= 1'b0;
      cyc(5);
      chk(32'(o[5]), 32'h1);
      want_ctrl <= 1'b0;
      cyc(3);
      chk(32'(o[5]), 32'h0);
      rst();
      el = 0;
      wt(2, 1'b1, 0, 4);
      aoc <= 1'b1;
      el = 0;
      wt(6, 1'b1, PC, PC + 3);
      chk(32'(o[2]), 32'h0);
      aoc <= 1'b0;
      cyc(5);
      chk(32'(o[6]), 32'h1);
      want_ana <= 1'b0;
      cyc(3);
      chk(32'(o[6]), 32'h0);
      want_ana <= 1'b1;
      el = 0;
      wt(2, 1'b1, 1, 4);
      rst();
      go();
      wt(7, 1'b1, PD - 1, PD + 1);
      chk(32'(o[2:0]), 32'h0);
      rst();
      preg <= 1'b1;
      go();
      wt(1, 1'b1, NE - 1, NE + 1);
      wt(7, 1'b1, NE + ND - 1, NE + ND + 1);
      rst();
      preg <= 1'b1;
      sce <= 1'b1;
      n250 <= 1'b1;
      go();
      wt(8, 1'b1, NE - 1, NE + 1);
      chk(32'(o[2:0]), 32'h4);
      rst();
      preg <= 1'b1;
      go();
      wt(0, 1'b1, 1, 2);
      hot_in <= 1'b1;
      el = 0;
      wt(9, 1'b1, 1, 4);
      chk(32'(o[2:0]), 32'h0);
      hot_in <= 1'b0;
      cyc(5);
      chk(32'(o[9]), 32'h1);
      cool <= 1'b1;
      el = 0;
      wt(9, 1'b0, 1, 4);
      wt(0, 1'b1, 1, 6);
      conclude();
   end
endmodule
`default_nettype wire
